// file: core/dpll_bandwidth_calib_regs.sv
// Bandwidth select, integral clamp and oscillator calibration registers
//
// Contract
// [RULE1] Auto bit high: output loop picks locked or acquisition bandwidth by lock state.
// [RULE2] Auto bit low: output loop always uses locked bandwidth.
// [RULE3] Clamp bit high: integral path frozen at min or max frequency; low: never.
// [RULE4] While integral path is frozen, reported loop frequency also stays frozen.
// [RULE5] Read-write calibration low byte, bits 7..0, resets to 0x99.
// [RULE6] Bandwidth choice and clamp act only on the output-path loop.
// [RULE7] Calibration high byte in next register; both form one 16-bit word.
// [RULE8] Unused bandwidth-select bits read zero and have no effect.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module dpll_bandwidth_calib_regs
    import bw_calib_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic out_loop_locked,
    input wire logic out_loop_at_limit,
    input wire logic [FREQ_W-1:0] out_loop_freq,
    output logic use_acquisition_bw,
    output logic integral_freeze,
    output logic [FREQ_W-1:0] reported_loop_frequency,
    output logic [2*DATA_W-1:0] oscillator_calibration
);

    logic [DATA_W-1:0] loop_bandwidth_select_reg;
    logic [DATA_W-1:0] oscillator_calibration_low_reg;
    logic [DATA_W-1:0] oscillator_calibration_high_reg;
    logic [DATA_W-1:0] rdata_next;
    logic acq_next;
    logic freeze_next;
    logic [FREQ_W-1:0] freq_next;
    logic bandwidth_auto_choose;
    logic integral_clamp_enable;
    logic wr_bw;
    logic wr_low;
    logic wr_high;
    logic hit_bw;
    logic hit_low;
    logic hit_high;
    logic hit_any;

    // Exact address match, shared by write and read decode
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] target);
        addr_hit = (a == target);
    endfunction

    // Keeps only the two live select bits; used at write and in its check
    function automatic logic [DATA_W-1:0] keep_select_bits(input logic [DATA_W-1:0] d);
        keep_select_bits = d & LOOP_BW_SEL_MASK;
    endfunction

    // Address match, one wire per register
    assign hit_bw = addr_hit(reg_addr, LOOP_BW_SEL_ADDR);
    assign hit_low = addr_hit(reg_addr, OSC_CAL_LOW_ADDR);
    assign hit_high = addr_hit(reg_addr, OSC_CAL_HIGH_ADDR);
    assign hit_any = hit_bw || hit_low || hit_high;

    // Write decode
    assign wr_bw = reg_wr && hit_bw;
    assign wr_low = reg_wr && hit_low;
    assign wr_high = reg_wr && hit_high;

    // Field extraction
    assign bandwidth_auto_choose = loop_bandwidth_select_reg[AUTO_BIT];
    assign integral_clamp_enable = loop_bandwidth_select_reg[CLAMP_BIT];

    // Control outputs; these feed only the output-path loop
    assign acq_next = bandwidth_auto_choose && !out_loop_locked; // [RULE1] [RULE2] [RULE6]
    assign freeze_next = integral_clamp_enable && out_loop_at_limit; // [RULE3] [RULE6]
    // Hold the last reported value while frozen so software sees a stable figure
    assign freq_next = freeze_next ? reported_loop_frequency : out_loop_freq; // [RULE4]

    // Read mux; unmapped addresses read zero
    assign rdata_next = !reg_rd ? READ_ZERO :
        hit_bw ? loop_bandwidth_select_reg :
        hit_low ? oscillator_calibration_low_reg :
        hit_high ? oscillator_calibration_high_reg : READ_ZERO;

    // Bandwidth select; unused bits never stored so they cannot reach the loop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            loop_bandwidth_select_reg <= LOOP_BW_SEL_RESET;
        end else if (wr_bw) begin
            loop_bandwidth_select_reg <= keep_select_bits(reg_wdata); // [RULE8]
        end
    end

    // Calibration low byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oscillator_calibration_low_reg <= OSC_CAL_LOW_RESET;
        end else if (wr_low) begin
            oscillator_calibration_low_reg <= reg_wdata; // [RULE5]
        end
    end

    // Calibration high byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oscillator_calibration_high_reg <= OSC_CAL_HIGH_RESET;
        end else if (wr_high) begin
            oscillator_calibration_high_reg <= reg_wdata; // [RULE7]
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= READ_ZERO;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // Bandwidth choice towards the output loop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            use_acquisition_bw <= 1'b0;
        end else begin
            use_acquisition_bw <= acq_next; // [RULE1] [RULE2]
        end
    end

    // Integral freeze towards the output loop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            integral_freeze <= 1'b0;
        end else begin
            integral_freeze <= freeze_next; // [RULE3]
        end
    end

    // Reported frequency; held in step with the freeze
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reported_loop_frequency <= FREQ_RESET;
        end else begin
            reported_loop_frequency <= freq_next; // [RULE4]
        end
    end

    // Word follows the byte registers one cycle later
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oscillator_calibration <= {OSC_CAL_HIGH_RESET, OSC_CAL_LOW_RESET};
        end else begin
            oscillator_calibration <= {oscillator_calibration_high_reg,
                oscillator_calibration_low_reg}; // [RULE7]
        end
    end

    // Locked bandwidth whenever auto choice is off
    locked_bw_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !$past(bandwidth_auto_choose) |-> !use_acquisition_bw) // [RULE2]
        else $error("acquisition bandwidth used with auto choice off");

    // Auto choice follows lock state
    auto_bw_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(bandwidth_auto_choose) |-> use_acquisition_bw == !$past(out_loop_locked)) // [RULE1]
        else $error("auto bandwidth does not follow lock");

    // Freeze only with clamp enabled and limit reached
    clamp_freeze_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        integral_freeze == ($past(integral_clamp_enable) && $past(out_loop_at_limit))) // [RULE3]
        else $error("integral freeze mismatch");

    // Reported frequency stable while frozen
    freq_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        integral_freeze ##1 integral_freeze |-> $stable(reported_loop_frequency)) // [RULE4]
        else $error("reported frequency moved while frozen");

    // Frequency tracks when not frozen
    freq_track_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !integral_freeze |-> reported_loop_frequency == $past(out_loop_freq)) // [RULE4]
        else $error("reported frequency not tracking");

    // Low byte write reads back
    cal_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_low ##1 reg_rd && reg_addr == OSC_CAL_LOW_ADDR && !reg_wr |=>
        reg_rdata == $past(reg_wdata, 2)) // [RULE5]
        else $error("calibration low byte readback wrong");

    // Combined word matches bytes
    cal_word_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        oscillator_calibration == {$past(oscillator_calibration_high_reg),
        $past(oscillator_calibration_low_reg)}) // [RULE7]
        else $error("calibration word mismatch");

    // Unused bits read zero
    unused_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(reg_rd) && $past(reg_addr) == LOOP_BW_SEL_ADDR |->
        (reg_rdata & ~LOOP_BW_SEL_MASK) == READ_ZERO) // [RULE8]
        else $error("unused select bits not zero");

    // Read data zero outside the read answer cycle
    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
        !$past(reg_rd) |-> reg_rdata == READ_ZERO)
        else $error("read data not zero when idle");

    // Select register read returns stored value
    bw_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE8]
        $past(reg_rd) && $past(hit_bw) |-> reg_rdata == $past(loop_bandwidth_select_reg))
        else $error("select register read wrong");

    // Low byte read returns stored value
    low_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
        $past(reg_rd) && $past(hit_low) |-> reg_rdata == $past(oscillator_calibration_low_reg))
        else $error("low byte read wrong");

    // High byte read returns stored value
    high_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE7]
        $past(reg_rd) && $past(hit_high) |-> reg_rdata == $past(oscillator_calibration_high_reg))
        else $error("high byte read wrong");

    // Unmapped read gives zero
    unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE8]
        $past(reg_rd) && !$past(hit_any) |-> reg_rdata == READ_ZERO)
        else $error("unmapped read not zero");

    // Select write keeps only live bits
    bw_write_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE8]
        $past(wr_bw) |-> loop_bandwidth_select_reg == keep_select_bits($past(reg_wdata)))
        else $error("select write wrong");

    // Select register unchanged without its write
    bw_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE8]
        !$past(wr_bw) |-> $stable(loop_bandwidth_select_reg))
        else $error("select register changed without write");

    // Unused select bits never stored
    unused_store_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE8]
        (loop_bandwidth_select_reg & ~LOOP_BW_SEL_MASK) == READ_ZERO)
        else $error("unused select bits stored");

    // Low byte write lands
    low_write_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
        $past(wr_low) |-> oscillator_calibration_low_reg == $past(reg_wdata))
        else $error("low byte write wrong");

    // Low byte unchanged without its write
    low_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
        !$past(wr_low) |-> $stable(oscillator_calibration_low_reg))
        else $error("low byte changed without write");

    // High byte write lands
    high_write_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE7]
        $past(wr_high) |-> oscillator_calibration_high_reg == $past(reg_wdata))
        else $error("high byte write wrong");

    // High byte unchanged without its write
    high_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE7]
        !$past(wr_high) |-> $stable(oscillator_calibration_high_reg))
        else $error("high byte changed without write");

    // Word low half is the low byte
    word_low_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
        oscillator_calibration[DATA_W-1:0] == $past(oscillator_calibration_low_reg))
        else $error("word low half wrong");

    // Word high half is the high byte
    word_high_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE7]
        oscillator_calibration[2*DATA_W-1:DATA_W] == $past(oscillator_calibration_high_reg))
        else $error("word high half wrong");

    // Acquisition bandwidth only while unlocked
    acq_unlocked_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE1]
        use_acquisition_bw |-> !$past(out_loop_locked))
        else $error("acquisition bandwidth while locked");

    // Locked loop keeps locked bandwidth
    acq_locked_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE1]
        $past(out_loop_locked) |-> !use_acquisition_bw)
        else $error("locked loop left locked bandwidth");

    // Acquisition bandwidth needs auto choice
    acq_needs_auto_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE2]
        use_acquisition_bw |-> $past(bandwidth_auto_choose))
        else $error("acquisition bandwidth without auto choice");

    // No freeze with clamp disabled
    clamp_off_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE3]
        !$past(integral_clamp_enable) |-> !integral_freeze)
        else $error("freeze with clamp disabled");

    // No freeze away from the limits
    limit_off_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE3]
        !$past(out_loop_at_limit) |-> !integral_freeze)
        else $error("freeze away from limit");

    // Freeze follows clamp at a limit
    freeze_on_limit_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE3]
        $past(integral_clamp_enable) && $past(out_loop_at_limit) |-> integral_freeze)
        else $error("no freeze at limit");

    // Reported frequency does not move on a frozen cycle
    freeze_stable_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE4]
        integral_freeze |-> $stable(reported_loop_frequency))
        else $error("reported frequency moved on freeze");

    // Frozen value is the one held before
    reported_held_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE4]
        $past(integral_clamp_enable) && $past(out_loop_at_limit) |->
        reported_loop_frequency == $past(reported_loop_frequency))
        else $error("reported frequency not held");

endmodule

// file: core/bw_calib_pkg.sv
// Register map and field layout of the loop bandwidth and calibration slice
package bw_calib_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int FREQ_W = 24;
    localparam logic [ADDR_W-1:0] LOOP_BW_SEL_ADDR = 7'h3B;
    localparam logic [ADDR_W-1:0] OSC_CAL_LOW_ADDR = 7'h3C;
    localparam logic [ADDR_W-1:0] OSC_CAL_HIGH_ADDR = 7'h3D;
    localparam int AUTO_BIT = 7;
    localparam int CLAMP_BIT = 3;
    // Only bits 7 and 3 of the bandwidth select register exist
    localparam logic [DATA_W-1:0] LOOP_BW_SEL_MASK = 8'h88;
    localparam logic [DATA_W-1:0] LOOP_BW_SEL_RESET = 8'h88;
    localparam logic [DATA_W-1:0] OSC_CAL_LOW_RESET = 8'h99;
    localparam logic [DATA_W-1:0] OSC_CAL_HIGH_RESET = 8'h99;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 24'h000000;
endpackage

// file: verification/dpll_bandwidth_calib_regs_test.sv
// Self-checking bench for the bandwidth select and calibration registers
`timescale 1ns/100ps
module dpll_bandwidth_calib_regs_test;
    import bw_calib_pkg::*;
    logic clk_sys = 0;
    logic nrst = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic out_loop_locked = 1;
    logic out_loop_at_limit = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [FREQ_W-1:0] out_loop_freq = '0;
    logic [FREQ_W-1:0] reported_loop_frequency;
    logic [2*DATA_W-1:0] oscillator_calibration;
    logic use_acquisition_bw;
    logic integral_freeze;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    dpll_bandwidth_calib_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .out_loop_locked(out_loop_locked), .out_loop_at_limit(out_loop_at_limit),
        .out_loop_freq(out_loop_freq), .use_acquisition_bw(use_acquisition_bw),
        .integral_freeze(integral_freeze), .reported_loop_frequency(reported_loop_frequency),
        .oscillator_calibration(oscillator_calibration));
    always #25 clk_sys = ~clk_sys;
    // Whole run needs about 50 cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobes drop at the next edge, so back-to-back tasks never clash
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string w);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(w, exp, reg_rdata);
    endtask
    task automatic loop(input logic lk, input logic lim, input logic [FREQ_W-1:0] f);
        @(posedge clk_sys);
        out_loop_locked <= lk;
        out_loop_at_limit <= lim;
        out_loop_freq <= f;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic test_reset();
        rd(LOOP_BW_SEL_ADDR, 8'h88, "bw select reset");
        rd(OSC_CAL_LOW_ADDR, 8'h99, "cal low reset");
        rd(OSC_CAL_HIGH_ADDR, 8'h99, "cal high reset");
        chk("cal word reset", 24'h009999, oscillator_calibration);
        $display("test_reset done");
    endtask
    task automatic test_control();
        loop(1'b1, 1'b0, 24'h000100);
        wr(LOOP_BW_SEL_ADDR, 8'hFF);
        rd(LOOP_BW_SEL_ADDR, 8'h88, "bw select unused bits");
        loop(1'b0, 1'b0, 24'h000100);
        chk("acq bw unlocked", 24'h1, use_acquisition_bw);
        loop(1'b1, 1'b1, 24'h000200);
        chk("acq bw locked", 24'h0, use_acquisition_bw);
        chk("freeze at limit", 24'h1, integral_freeze);
        chk("frozen freq", 24'h000100, reported_loop_frequency);
        loop(1'b1, 1'b0, 24'h000300);
        chk("freeze released", 24'h0, integral_freeze);
        chk("freq follows", 24'h000300, reported_loop_frequency);
        wr(LOOP_BW_SEL_ADDR, 8'h77);
        rd(LOOP_BW_SEL_ADDR, 8'h00, "bw select cleared");
        loop(1'b0, 1'b1, 24'h000400);
        chk("locked bw forced", 24'h0, use_acquisition_bw);
        chk("no freeze", 24'h0, integral_freeze);
        chk("freq not held", 24'h000400, reported_loop_frequency);
        $display("test_control done");
    endtask
    task automatic test_cal();
        wr(OSC_CAL_LOW_ADDR, 8'h12);
        wr(OSC_CAL_HIGH_ADDR, 8'hAB);
        rd(OSC_CAL_LOW_ADDR, 8'h12, "cal low");
        rd(OSC_CAL_HIGH_ADDR, 8'hAB, "cal high");
        chk("cal word", 24'h00AB12, oscillator_calibration);
        rd(7'h7F, 8'h00, "unmapped read");
        $display("test_cal done");
    endtask
    // Write then read with no gap, then read data must fall back to zero
    task automatic test_bus();
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= OSC_CAL_LOW_ADDR;
        reg_wdata <= 8'h5A;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("read after write", 24'h00005A, reg_rdata);
        @(posedge clk_sys);
        #1 chk("read data idle", 24'h000000, reg_rdata);
        chk("cal word after write", 24'h00AB5A, oscillator_calibration);
        $display("test_bus done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        test_reset();
        test_control();
        test_cal();
        test_bus();
        test_done();
    end
endmodule
